/* File: rtl/pdm_ahb_slave.sv */
// AHB-Lite register slave front end for the power-down controller
`timescale 1ns/1ns
module pdm_ahb_slave (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   output logic wr_stb,
   output logic rd_stb,
   output logic [7:0] addr,
   output logic bad
);
   import pdm_pkg::*;

   logic next_wr_stb;
   logic next_rd_stb;
   logic [7:0] next_addr;
   logic next_bad;

   // ----------------------------------------
   // Address phase capture
   // ----------------------------------------
   always_comb begin
      next_wr_stb = 1'b0;
      next_rd_stb = 1'b0;
      next_addr = addr;
      next_bad = 1'b0;
      if (hsel && htrans[1] && hready) begin
         next_addr = haddr;
         next_wr_stb = hwrite;
         next_rd_stb = !hwrite;
         next_bad = (hsize != 3'b010) || (haddr[1:0] != 2'b00);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         addr <= 8'h00;
         bad <= 1'b0;
      end else if (ce) begin
         wr_stb <= next_wr_stb;
         rd_stb <= next_rd_stb;
         addr <= next_addr;
         bad <= next_bad;
      end
   end

endmodule : pdm_ahb_slave

/* File: rtl/pdm_pkg.sv */
// Package for the power-down mode controller: offsets, fields, types
package pdm_pkg;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_CSW = 8'h00;
   localparam logic [7:0] OFF_PERSEL = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_STRAP = 8'h0c;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int POWER_DOWN_FIELD_LSB = 10;
   localparam int POWER_DOWN_FIELD_MSB = 15;
   localparam logic [5:0] POWER_DOWN_FIELD_RESET = 6'h00;
   localparam logic [7:0] PERSEL_RESET = 8'h00;
   localparam int PERSEL_W = 7;

   // ----------------------------------------
   // Power-down field encodings
   // ----------------------------------------
   localparam logic [5:0] POWER_DOWN_FIELD_NONE = 6'h00;
   localparam logic [5:0] POWER_DOWN_FIELD_HALT_EN = 6'h09;
   localparam logic [5:0] POWER_DOWN_FIELD_HALT_ANY = 6'h11;
   localparam logic [5:0] POWER_DOWN_FIELD_PLL_OUT = 6'h1a;
   localparam logic [5:0] POWER_DOWN_FIELD_PLL_IN = 6'h1c;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int ENTRY_DELAY_CYC = 9;
   localparam logic [3:0] ENTRY_CNT = 4'(ENTRY_DELAY_CYC);

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      PDM_RUN = 2'b00,
      PDM_HALT = 2'b01,
      PDM_PLLOUT = 2'b11,
      PDM_PLLIN = 2'b10
   } pdm_state_e;

   typedef struct packed {
      logic host_port;
      logic pci;
      logic network_controller;
      logic mdio;
   } pdm_strap_s;

   typedef struct packed {
      logic halt;
      logic pll_out_stop;
      logic pll_in_stop;
      logic core_clk_gate;
   } pdm_pd_s;

endpackage : pdm_pkg

/* File: rtl/pdm_top.sv */
// Power-down mode controller with peripheral selection and AHB-Lite registers
//
// What this block does
// - Peripherals power down by pins, reset register default, or run-time writes.
// - Host, PCI, network and MDIO enables follow pins sampled once at reset release.
// - Audio, two serial, three video and I2C ports each have a select bit.
// - Only the core input clock is gated; other clocks pass untouched.
// - Power-down field sits at bits 15 to 10 of the control word.
// - Field is read/write, resets to zero; bits 14..10 wake and state.
// - Only five field codes are meaningful; others are reserved.
// - Chosen state takes effect nine cycles after the write.
// - PLL stop states end only by reset; outputs hold their state.
// - Halt exits on interrupt; service first only if all enables set.
`timescale 1ns/1ns
module pdm_top #(
   parameter int ENTRY_CYCLES = pdm_pkg::ENTRY_DELAY_CYC
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic HSEL,
   input wire logic [7:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire pdm_pkg::pdm_strap_s STRAP_PINS,
   input wire logic IRQ_ANY,
   input wire logic IRQ_ENABLED,
   input wire logic GLOBAL_INTERRUPT_ENABLE,
   input wire logic NONMASKABLE_INTERRUPT_ENABLE,
   output pdm_pkg::pdm_strap_s STRAP_ENABLES,
   output logic [6:0] PERIPH_ENABLES,
   output pdm_pkg::pdm_pd_s PD_STATE,
   output logic RUN_ISR
);
   import pdm_pkg::*;

   // ----------------------------------------
   // Bus front end
   // ----------------------------------------
   logic wr_stb;
   logic [7:0] addr;
   logic bad;

   pdm_ahb_slave u_bus (
      .clk(CLK),
      .rst_n(RST_N),
      .ce(CE),
      .hsel(HSEL),
      .haddr(HADDR),
      .htrans(HTRANS),
      .hwrite(HWRITE),
      .hsize(HSIZE),
      .hready(HREADY),
      .wr_stb(wr_stb),
      .rd_stb(),
      .addr(addr),
      .bad(bad)
   );

   function automatic pdm_state_e decode_power_down_field(input logic [5:0] f);
      case (f)
         POWER_DOWN_FIELD_HALT_EN: decode_power_down_field = PDM_HALT;
         POWER_DOWN_FIELD_HALT_ANY: decode_power_down_field = PDM_HALT;
         POWER_DOWN_FIELD_PLL_OUT: decode_power_down_field = PDM_PLLOUT;
         POWER_DOWN_FIELD_PLL_IN: decode_power_down_field = PDM_PLLIN;
         default: decode_power_down_field = PDM_RUN;
      endcase
   endfunction : decode_power_down_field

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [5:0] power_down_field;
   logic [PERSEL_W-1:0] peripheral_select_register;
   pdm_strap_s strap;
   logic strap_taken;
   logic [3:0] entry_cnt;
   logic pending;
   pdm_state_e state;
   logic run_isr;
   logic [31:0] rdata;

   logic [5:0] next_power_down_field;
   logic [PERSEL_W-1:0] next_peripheral_select_register;
   pdm_strap_s next_strap;
   logic next_strap_taken;
   logic [3:0] next_entry_cnt;
   logic next_pending;
   pdm_state_e next_state;
   logic next_run_isr;
   logic [31:0] next_rdata;
   logic halt_wake;
   logic rd_take;

   always_comb begin
      next_power_down_field = power_down_field;
      next_peripheral_select_register = peripheral_select_register;
      next_strap = strap;
      next_strap_taken = 1'b1;
      next_entry_cnt = entry_cnt;
      next_pending = pending;
      next_state = state;
      next_run_isr = 1'b0;
      next_rdata = 32'h0000_0000;
      halt_wake = 1'b0;
      // Read taken in its address phase so the data stands in the data phase
      rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE && (HSIZE == 3'b010)
         && (HADDR[1:0] == 2'b00);

      // Pins caught once at reset release
      if (!strap_taken) begin
         next_strap = STRAP_PINS;
      end

      if (wr_stb && !bad && addr == OFF_PERSEL) begin
         next_peripheral_select_register = HWDATA[PERSEL_W-1:0];
      end

      if (wr_stb && !bad && addr == OFF_CSW && state == PDM_RUN) begin
         // Field from bits 15 to 10
         next_power_down_field = HWDATA[POWER_DOWN_FIELD_MSB:POWER_DOWN_FIELD_LSB];
         next_entry_cnt = 4'(ENTRY_CYCLES);
         next_pending = 1'b1;
      end else if (pending) begin
         if (entry_cnt <= 4'h1) begin
            next_pending = 1'b0;
            next_state = decode_power_down_field(power_down_field);
         end else begin
            next_entry_cnt = entry_cnt - 4'h1;
         end
      end

      if (state == PDM_HALT) begin
         halt_wake = IRQ_ENABLED || (power_down_field[4] && IRQ_ANY);
         if (halt_wake) begin
            next_state = PDM_RUN;
            next_power_down_field = POWER_DOWN_FIELD_NONE;
            next_run_isr = IRQ_ENABLED && GLOBAL_INTERRUPT_ENABLE
               && NONMASKABLE_INTERRUPT_ENABLE;
         end
      end

      // PLL stop states held until reset
      if (state == PDM_PLLOUT || state == PDM_PLLIN) begin
         next_state = state;
      end

      // Post-edge values, so a write just ahead is seen
      if (rd_take) begin
         case (HADDR)
            OFF_CSW: next_rdata = {16'h0000, next_power_down_field, 10'h000};
            OFF_PERSEL: next_rdata = {25'h0, next_peripheral_select_register};
            OFF_STATUS: next_rdata = {28'h0, next_pending, 1'b0, next_state};
            OFF_STRAP: next_rdata = {28'h0, next_strap};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         power_down_field <= POWER_DOWN_FIELD_RESET;
         peripheral_select_register <= PERSEL_RESET[PERSEL_W-1:0];
         strap <= '0;
         strap_taken <= 1'b0;
         entry_cnt <= 4'h0;
         pending <= 1'b0;
         state <= PDM_RUN;
         run_isr <= 1'b0;
         rdata <= 32'h0000_0000;
      end else if (CE) begin
         power_down_field <= next_power_down_field;
         peripheral_select_register <= next_peripheral_select_register;
         strap <= next_strap;
         strap_taken <= next_strap_taken;
         entry_cnt <= next_entry_cnt;
         pending <= next_pending;
         state <= next_state;
         run_isr <= next_run_isr;
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         STRAP_ENABLES <= '0;
         PERIPH_ENABLES <= 7'h00;
         PD_STATE <= '0;
         RUN_ISR <= 1'b0;
      end else if (CE) begin
         STRAP_ENABLES <= next_strap;
         PERIPH_ENABLES <= next_peripheral_select_register;
         PD_STATE.halt <= (next_state == PDM_HALT);
         PD_STATE.pll_out_stop <= (next_state == PDM_PLLOUT);
         PD_STATE.pll_in_stop <= (next_state == PDM_PLLIN);
         PD_STATE.core_clk_gate <= (next_state != PDM_RUN);
         RUN_ISR <= next_run_isr;
      end
   end

   assign HRDATA = rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

endmodule : pdm_top

/* File: testbench/pdm_props.sv */
// Port checker for the power-down controller
`timescale 1ns/1ns
module pdm_props (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic IRQ_ANY,
   input wire logic IRQ_ENABLED,
   input wire logic GLOBAL_INTERRUPT_ENABLE,
   input wire logic NONMASKABLE_INTERRUPT_ENABLE,
   input wire pdm_pkg::pdm_strap_s STRAP_ENABLES,
   input wire pdm_pkg::pdm_pd_s PD_STATE,
   input wire logic RUN_ISR
);
   import pdm_pkg::*;
   logic [1:0] up;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // ----
   // Halt wake and hold steps
   // ----
   sequence s_wake;
      PD_STATE.halt && IRQ_ENABLED && CE;
   endsequence
   sequence s_quiet;
      PD_STATE.halt && !IRQ_ENABLED && !IRQ_ANY;
   endsequence
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) up <= 2'h0;
      else if (CE && up != 2'h3) up <= up + 2'h1;
   end
   chk_pll_out_kept: assert property (PD_STATE.pll_out_stop |=> PD_STATE.pll_out_stop)
      else $error("pll out stop left");
   chk_pll_in_kept: assert property (PD_STATE.pll_in_stop |=> PD_STATE.pll_in_stop)
      else $error("pll in stop left");
   chk_single_state: assert property ($onehot0(PD_STATE[3:1]) &&
      (PD_STATE.core_clk_gate == (|PD_STATE[3:1])))
      else $error("two states at once");
   chk_halt_wake: assert property (s_wake |=> !PD_STATE.halt)
      else $error("halt kept after interrupt");
   chk_halt_hold: assert property (s_quiet |=> PD_STATE.halt)
      else $error("halt left without interrupt");
   chk_isr_cause: assert property (RUN_ISR |-> $fell(PD_STATE.halt) &&
      $past(IRQ_ENABLED && GLOBAL_INTERRUPT_ENABLE && NONMASKABLE_INTERRUPT_ENABLE))
      else $error("service without cause");
   chk_isr_pulse: assert property (RUN_ISR |=> !RUN_ISR)
      else $error("service pulse too long");
   chk_strap_fixed: assert property (up == 2'h3 |-> $stable(STRAP_ENABLES))
      else $error("strap enables changed");
endmodule : pdm_props
bind pdm_top pdm_props u_props (.CLK, .RST_N, .CE, .IRQ_ANY, .IRQ_ENABLED,
   .GLOBAL_INTERRUPT_ENABLE, .NONMASKABLE_INTERRUPT_ENABLE, .STRAP_ENABLES, .PD_STATE, .RUN_ISR);

/* File: testbench/pdm_top_test.sv */
// Self-checking bench for the power-down controller
`timescale 1ns/1ns
module pdm_top_test;
   import pdm_pkg::*;
   localparam int EC = 2;
   logic clk = 0, rst_n = 0, ce = 1, hsel = 0, hwrite = 0, irq_any = 0, irq_en = 0;
   logic global_interrupt_enable = 0, nonmaskable_interrupt_enable = 0, obs = 0, sel = 0;
   logic [7:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 0, exp_v;
   logic [6:0] ps = 0;
   logic [5:0] f;
   pdm_strap_s strap = 0, strap0;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, run_isr;
   wire pdm_strap_s strap_en;
   wire logic [6:0] periph;
   wire pdm_pd_s pd;
   wire logic [31:0] pins = {14'h0, hresp, run_isr, pd, strap_en, 1'b0, periph};
   logic [31:0] q[$];
   int miscompares = 0, n_tests = 0, n;
   always #5 clk = ~clk;
   pdm_top #(.ENTRY_CYCLES(EC)) uut (.CLK(clk), .RST_N(rst_n), .CE(ce), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .STRAP_PINS(strap), .IRQ_ANY(irq_any), .IRQ_ENABLED(irq_en),
      .GLOBAL_INTERRUPT_ENABLE(global_interrupt_enable), .NONMASKABLE_INTERRUPT_ENABLE(nonmaskable_interrupt_enable),
      .STRAP_ENABLES(strap_en), .PERIPH_ENABLES(periph), .PD_STATE(pd), .RUN_ISR(run_isr));
   // Monitor takes the oldest note per result
   always @(negedge clk) begin
      if (obs) begin
         exp_v = q.pop_front();
         n_tests++;
         if ((sel ? pins : hrdata) !== exp_v) begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, sel ? pins : hrdata, exp_v);
         end
      end
   end
   function automatic logic [31:0] pv(input logic [2:0] p, input logic isr = 1'b0);
      return {14'h0, 1'b0, isr, p, |p, strap0, 1'b0, ps};
   endfunction : pv
   task automatic aph(input logic [7:0] a, input logic w);
      @(posedge clk);
      hsel <= 1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
   endtask : aph
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      aph(a, 1);
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      aph(a, 0);
      q.push_back(e);
      obs <= 1;
      sel <= 0;
      do @(posedge clk); while (hreadyout !== 1'b1);
      obs <= 0;
   endtask : rd
   task automatic chk(input logic [31:0] e);
      @(posedge clk);
      q.push_back(e);
      obs <= 1;
      sel <= 1;
      @(posedge clk);
      obs <= 0;
   endtask : chk
   task automatic enter(input logic [5:0] c, input logic [2:0] p);
      wr(OFF_CSW, 32'(c) << POWER_DOWN_FIELD_LSB);
      n = 0;
      while (pd[3:1] !== p && n < 20) begin
         @(negedge clk);
         n++;
      end
      n_tests++;
      if (n < EC || n > EC + 1) begin
         miscompares++;
         $display("MISMATCH %0t entry took %0d", $time, n);
      end
      @(posedge clk);
   endtask : enter
   task automatic end_of_test;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   initial begin
      #200000;
      miscompares++;
      end_of_test;
   end
   initial begin
      void'($urandom(32'h8eb6));
      strap = 4'($urandom);
      strap0 = strap;
      repeat (10) @(posedge clk);
      rst_n <= 1;
      chk(pv(3'h0));
      strap <= ~strap0;
      rd(OFF_STRAP, 32'(strap0));
      rd(OFF_CSW, 32'h0);
      rd(OFF_PERSEL, 32'h0);
      rd(8'h10, 32'h0);
      for (int i = 0; i < 4; i++) begin
         ps = 7'($urandom);
         wr(OFF_PERSEL, 32'(ps));
         rd(OFF_PERSEL, 32'(ps));
         chk(pv(3'h0));
      end
      ce <= 0;
      repeat (3) @(posedge clk);
      ce <= 1;
      for (int i = 0; i < 4; i++) begin
         do f = {1'b0, 5'($urandom)};
         while (f inside {POWER_DOWN_FIELD_NONE, POWER_DOWN_FIELD_HALT_EN, POWER_DOWN_FIELD_HALT_ANY, POWER_DOWN_FIELD_PLL_OUT, POWER_DOWN_FIELD_PLL_IN});
         wr(OFF_CSW, 32'(f) << POWER_DOWN_FIELD_LSB);
         repeat (EC + 3) @(posedge clk);
         chk(pv(3'h0));
         rd(OFF_CSW, 32'(f) << POWER_DOWN_FIELD_LSB);
      end
      wr(OFF_CSW, 32'h0);
      global_interrupt_enable <= 1;
      nonmaskable_interrupt_enable <= 1;
      enter(POWER_DOWN_FIELD_HALT_EN, 3'h4);
      irq_any <= 1;
      chk(pv(3'h4));
      irq_any <= 0;
      irq_en <= 1;
      chk(pv(3'h0, 1'b1));
      irq_en <= 0;
      global_interrupt_enable <= 0;
      rd(OFF_CSW, 32'h0);
      enter(POWER_DOWN_FIELD_HALT_ANY, 3'h4);
      irq_any <= 1;
      chk(pv(3'h0));
      irq_any <= 0;
      for (int i = 0; i < 2; i++) begin
         enter(i ? POWER_DOWN_FIELD_PLL_IN : POWER_DOWN_FIELD_PLL_OUT, i ? 3'h1 : 3'h2);
         irq_any <= 1;
         irq_en <= 1;
         wr(OFF_CSW, 32'h0);
         chk(pv(i ? 3'h1 : 3'h2));
         rd(OFF_CSW, 32'(i ? POWER_DOWN_FIELD_PLL_IN : POWER_DOWN_FIELD_PLL_OUT) << POWER_DOWN_FIELD_LSB);
         rd(OFF_STATUS, i ? 32'h2 : 32'h3);
         irq_any <= 0;
         irq_en <= 0;
         strap <= strap0;
         rst_n <= 0;
         repeat (10) @(posedge clk);
         rst_n <= 1;
         ps = 0;
         chk(pv(3'h0));
      end
      end_of_test;
   end
endmodule : pdm_top_test
